// ===== hw/lcd_port_pkg.sv
// constants, field positions and carrier types of the lcd segment driver host port
// assumes a single 125 MHz clock and a synchronous active-high reset
// Functional notes
// - end command leaves read-modify-write and restores the saved column address
// - command write of byte 1110_0010 starts soft reset initialization
// - initialization sets display start line to the first line
// - initialization sets the page register to page 3
// - soft reset leaves the display memory untouched
// - display off together with static drive on enters power save
// - power save stops drive sequencing, segments held at lcd drive level
// - power save ignores the display clock input
// - power save keeps memory and all mode settings
// - display on or static drive off leaves power save
// - reset pin level picks 68-style (high) or 80-style (low) bus
// - chip select high detaches the bus but soft reset still accepted
// - register select high: reads and writes reach display data
// - register select low: read gives status, write gives command
// - written bytes pass a bus holder and commit one step later
// - first read after address set or write returns stale holder data
// - read-modify-write: writes advance column, reads leave it
// - column increment stops at the end value, page never changes
// - status busy bit is one during operations and reset cycles
package lcd_port_pkg;
   localparam int CLK_NS = 8;
   localparam int INIT_NS = 1000;
   localparam logic [6:0] INIT_CYCLES = 7'((INIT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [1:0] MODE_CAPTURE_CYCLES = 2'h3;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_WIDTH = 9;
   localparam logic [7:0] MASK_COL = 8'h80;
   localparam logic [7:0] CMD_COL = 8'h00;
   localparam logic [7:0] MASK_PAGE = 8'hfc;
   localparam logic [7:0] CMD_PAGE = 8'hb8;
   localparam logic [7:0] MASK_BIT0 = 8'hfe;
   localparam logic [7:0] MASK_ALL = 8'hff;
   localparam logic [7:0] CMD_ADC = 8'ha0;
   localparam logic [7:0] CMD_STATIC = 8'ha4;
   localparam logic [7:0] CMD_DUTY = 8'ha8;
   localparam logic [7:0] CMD_DISP = 8'hae;
   localparam logic [7:0] CMD_RMW = 8'he0;
   localparam logic [7:0] CMD_END = 8'hee;
   localparam logic [7:0] CMD_RESET = 8'he2;
   localparam logic [6:0] COL_END = 7'h50;
   localparam logic [1:0] INIT_PAGE = 2'h3;
   localparam logic [4:0] INIT_LINE = 5'h00;
   localparam logic [4:0] LINE_LAST16 = 5'h0f;
   localparam logic RST_ADC_NORMAL = 1'b1;
   localparam logic [3:0] STATUS_LOW = 4'h0;

   typedef struct packed {
      logic rs;
      logic [7:0] data;
   } wr_item_type;

   typedef struct packed {
      logic power_save;
      logic hold_lcd_drive_level;
      logic drive_run;
      logic display_on;
      logic static_on;
      logic adc_normal;
      logic duty32;
      logic [4:0] start_line;
      logic [4:0] drive_line;
      logic [1:0] page;
      logic [6:0] column;
   } disp_ctrl_type;
endpackage

// ===== hw/lcd_segment_mpu_port_ctrl.sv
// host bus port, bus holder, command control and power save of the segment driver
// assumes asynchronous bus pins and display clock, one internal clock, sync reset
`timescale 1ns/1ps

module wr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
   } fifo_state_type;
   fifo_state_type s;
   fifo_state_type n;
   logic push;
   logic pop;

   assign in_ready = s.count != (AW+1)'(DEPTH);
   assign out_valid = s.count != '0;
   assign out_data = s.mem[s.rptr];

   always_comb
   begin
      n = s;
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      if (push)
      begin
         n.mem[s.wptr] = in_data;
         n.wptr = s.wptr + 1'b1;
      end
      if (pop)
         n.rptr = s.rptr + 1'b1;
      if (push & ~pop)
         n.count = s.count + 1'b1;
      else if (pop & ~push)
         n.count = s.count - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         s <= '0;
      else
         s <= n;
   end
endmodule // wr_fifo

module lcd_segment_mpu_port_ctrl (
   input wire logic clk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic register_select,
   input wire logic strobe_e_rd_n,
   input wire logic rw_wr_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic hw_reset_pin,
   input wire logic display_clock_in,
   output lcd_port_pkg::disp_ctrl_type settings,
   output logic busy
);
   import lcd_port_pkg::*;

   typedef struct packed {
      logic cs_s1, cs_s2, rs_s1, rs_s2, e_s1, e_s2, rw_s1, rw_s2;
      logic rst_s1, rst_s2, dclk_s1, dclk_s2, dclk_s3;
      logic [7:0] d_s1;
      logic [7:0] d_s2;
      logic act_q, wr_q, rs_q, cs_q;
      logic [7:0] dat_q;
      logic captured, mode68;
      logic [1:0] cap_cnt;
      logic [7:0] holder;
      logic rmw;
      logic [6:0] col_save;
      logic disp_on, static_on, adc_normal, duty32, psave;
      logic [4:0] start_line;
      logic [4:0] drive_line;
      logic [1:0] page;
      logic [6:0] column;
      logic [6:0] init_cnt;
      logic [7:0] dout;
      logic doe;
      logic ram_we;
      logic [8:0] ram_addr;
      logic [7:0] ram_wdata;
   } port_state_type;

   port_state_type s;
   port_state_type n;
   logic [7:0] ram [0:511];
   logic [7:0] ram_rdata;
   logic rst_act, rd_on, wr_on, end_acc, sel, push_v, f_iready;
   logic f_ovalid, f_oready, pop, exec_cmd, exec_reset, dclk_edge;
   wr_item_type f_in, f_out;
   logic [7:0] status;

   function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] v,
                                   input logic [7:0] m);
      return (b & m) == v;
   endfunction

   wr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) wr_fifo_inst (
      .clk(clk),
      .srst(srst),
      .in_valid(push_v),
      .in_ready(f_iready),
      .in_data(f_in),
      .out_valid(f_ovalid),
      .out_ready(f_oready),
      .out_data(f_out)
   );

   assign ram_rdata = ram[{s.page, s.column}];
   // bus style is known only once captured; until then the pin counts as reset
   assign rst_act = ~s.captured | (s.rst_s2 != s.mode68);
   assign rd_on = s.captured & (s.mode68 ? (s.e_s2 & s.rw_s2) : ~s.e_s2);
   assign wr_on = s.captured & (s.mode68 ? (s.e_s2 & ~s.rw_s2) : ~s.rw_s2);
   assign end_acc = s.act_q & ~(rd_on | wr_on);
   assign sel = ~s.cs_q;
   assign f_oready = (s.init_cnt == '0) & ~rst_act;
   assign pop = f_ovalid & f_oready;
   assign exec_cmd = pop & ~f_out.rs;
   assign exec_reset = exec_cmd & (f_out.data == CMD_RESET);
   assign dclk_edge = s.dclk_s2 & ~s.dclk_s3;
   // a full holder queue shows as busy; the host must wait, not overrun it
   assign busy = (s.init_cnt != '0) | f_ovalid | ~f_iready | rst_act;
   assign status = {busy, s.adc_normal, ~s.disp_on,
                    rst_act | (s.init_cnt != '0), STATUS_LOW};
   // soft reset passes even while detached
   assign push_v = end_acc & s.wr_q & ~rst_act
                   & (sel | (~s.rs_q & s.dat_q == CMD_RESET));
   assign f_in = '{rs: s.rs_q, data: s.dat_q};
   assign data_out = s.dout;
   assign data_oe = s.doe;
   assign settings = '{power_save: s.psave, hold_lcd_drive_level: s.psave,
                       drive_run: ~s.psave, display_on: s.disp_on,
                       static_on: s.static_on, adc_normal: s.adc_normal,
                       duty32: s.duty32, start_line: s.start_line,
                       drive_line: s.drive_line, page: s.page,
                       column: s.column};

   always_comb
   begin
      n = s;
      n.ram_we = 1'b0;
      n.cs_s1 = cs_n;
      n.cs_s2 = s.cs_s1;
      n.rs_s1 = register_select;
      n.rs_s2 = s.rs_s1;
      n.e_s1 = strobe_e_rd_n;
      n.e_s2 = s.e_s1;
      n.rw_s1 = rw_wr_n;
      n.rw_s2 = s.rw_s1;
      n.rst_s1 = hw_reset_pin;
      n.rst_s2 = s.rst_s1;
      n.dclk_s1 = display_clock_in;
      n.dclk_s2 = s.dclk_s1;
      n.dclk_s3 = s.dclk_s2;
      n.d_s1 = data_in;
      n.d_s2 = s.d_s1;
      if (!s.captured)
      begin
         if (s.cap_cnt == MODE_CAPTURE_CYCLES)
         begin
            n.captured = 1'b1;
            n.mode68 = s.rst_s2;
         end
         else
            n.cap_cnt = s.cap_cnt + 2'h1;
      end
      n.act_q = rd_on | wr_on;
      if (rd_on | wr_on)
      begin
         n.wr_q = wr_on;
         n.rs_q = s.rs_s2;
         n.cs_q = s.cs_s2;
         n.dat_q = s.d_s2;
      end
      n.doe = rd_on & ~s.cs_s2;
      n.dout = s.rs_s2 ? s.holder : status;
      if (push_v & f_iready)
         n.holder = s.dat_q;
      if (end_acc & ~s.wr_q & sel & s.rs_q & ~rst_act)
      begin
         n.holder = ram_rdata;
         if (~s.rmw & (s.column < COL_END))
            n.column = s.column + 7'h01;
      end
      if (s.init_cnt != '0)
         n.init_cnt = s.init_cnt - 7'h01;
      if (pop & f_out.rs)
      begin
         n.ram_we = 1'b1;
         n.ram_addr = {s.page, s.column};
         n.ram_wdata = f_out.data;
         if (s.column < COL_END)
            n.column = s.column + 7'h01;
      end
      else if (exec_cmd)
      begin
         if (cmd_is(f_out.data, CMD_COL, MASK_COL))
         begin
            if (!s.rmw)
               n.column = f_out.data[6:0];
         end
         else if (cmd_is(f_out.data, CMD_PAGE, MASK_PAGE))
            n.page = f_out.data[1:0];
         else if (cmd_is(f_out.data, CMD_ADC, MASK_BIT0))
            n.adc_normal = ~f_out.data[0];
         else if (cmd_is(f_out.data, CMD_STATIC, MASK_BIT0))
            n.static_on = f_out.data[0];
         else if (cmd_is(f_out.data, CMD_DUTY, MASK_BIT0))
            n.duty32 = f_out.data[0];
         else if (cmd_is(f_out.data, CMD_DISP, MASK_BIT0))
            n.disp_on = f_out.data[0];
         else if (cmd_is(f_out.data, CMD_RMW, MASK_ALL))
         begin
            n.rmw = 1'b1;
            n.col_save = s.column;
         end
         else if (cmd_is(f_out.data, CMD_END, MASK_ALL))
         begin
            if (s.rmw)
               n.column = s.col_save;
            n.rmw = 1'b0;
         end
         else if (cmd_is(f_out.data, CMD_RESET, MASK_ALL))
         begin
            // memory is left alone; only start line, page and the init counter are reloaded
            n.start_line = INIT_LINE;
            n.page = INIT_PAGE;
            n.init_cnt = INIT_CYCLES;
         end
      end
      if (rst_act)
      begin
         n.rmw = 1'b0;
         n.start_line = INIT_LINE;
         n.page = INIT_PAGE;
         n.init_cnt = INIT_CYCLES;
      end
      // display clock edges only move the line counter outside power save
      if (dclk_edge & ~s.psave)
      begin
         if (~s.duty32 & (s.drive_line == LINE_LAST16))
            n.drive_line = '0;
         else
            n.drive_line = s.drive_line + 5'h01;
      end
      n.psave = ~n.disp_on & n.static_on;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s <= '0;
         s.cs_s1 <= 1'b1;
         s.cs_s2 <= 1'b1;
         s.cs_q <= 1'b1;
         s.adc_normal <= RST_ADC_NORMAL;
         s.page <= INIT_PAGE;
      end
      else
         s <= n;
   end

   // no reset on the array: a soft or hard reset never disturbs pixels
   always_ff @(posedge clk)
   begin
      if (s.ram_we)
         ram[s.ram_addr] <= s.ram_wdata;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_end_restore;
      exec_cmd && f_out.data == CMD_END && s.rmw |=> s.column == $past(s.col_save) && !s.rmw;
   endproperty
   a_end_restore: assert property (p_end_restore) else $error("end did not restore column");

   property p_reset_init;
      exec_reset && !rst_act |=> s.page == INIT_PAGE && s.start_line == INIT_LINE;
   endproperty
   a_reset_init: assert property (p_reset_init) else $error("soft reset init wrong");

   property p_reset_busy;
      exec_reset |=> busy [*8];
   endproperty
   a_reset_busy: assert property (p_reset_busy) else $error("busy dropped in init");

   property p_no_ram_write_init;
      exec_reset |=> !s.ram_we ##1 !s.ram_we;
   endproperty
   a_no_ram_write_init: assert property (p_no_ram_write_init) else $error("ram hit by reset");

   property p_psave_line_hold;
      s.psave && n.psave |=> $stable(s.drive_line);
   endproperty
   a_psave_line_hold: assert property (p_psave_line_hold) else $error("line moved in save");

   property p_disp_on_exit;
      exec_cmd && f_out.data == (CMD_DISP | 8'h01) |=> !s.psave;
   endproperty
   a_disp_on_exit: assert property (p_disp_on_exit) else $error("power save not left");

   property p_detach;
      s.cs_s2 |=> !data_oe;
   endproperty
   a_detach: assert property (p_detach) else $error("bus driven while detached");

   property p_status_low;
      rd_on && !s.cs_s2 && !s.rs_s2 |=> data_oe && data_out[3:0] == STATUS_LOW;
   endproperty
   a_status_low: assert property (p_status_low) else $error("status byte malformed");

   property p_rmw_read_hold;
      s.rmw && end_acc && !s.wr_q && s.rs_q && !pop |=> $stable(s.column);
   endproperty
   a_rmw_read_hold: assert property (p_rmw_read_hold) else $error("rmw read moved column");
endmodule // lcd_segment_mpu_port_ctrl

// ===== test/host_bus_model.sv
// behavioural 68-style or 80-style host bus master for the segment driver port
// assumes the driver's captured bus style matches the one set by park, 68-style by default
`timescale 1ns/1ps
module host_bus_model (
   input wire logic clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic busy,
   output logic cs_n,
   output logic register_select,
   output logic strobe_e_rd_n,
   output logic rw_wr_n,
   output logic [7:0] data_in
);
   logic bus80 = 1'b0;

   // idle levels of the chosen bus style; call while the driver is held in reset
   task automatic park(input logic m80);
      bus80 = m80;
      cs_n <= 1'b1;
      strobe_e_rd_n <= m80;
      rw_wr_n <= 1'b1;
   endtask

   initial
   begin
      cs_n = 1'b1;
      register_select = 1'b0;
      strobe_e_rd_n = 1'b0;
      rw_wr_n = 1'b1;
      data_in = 8'h5a;
   end

   // one whole bus cycle; wt waits for busy low first, a bounded wait
   task automatic access(input logic rs, input logic rd, input logic sel, input logic wt,
         input logic [7:0] wd, output logic [7:0] rv, output logic oe, output logic ok);
      int n;
      n = 0;
      ok = 1'b1;
      @(negedge clk);
      while (wt && busy !== 1'b0 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 400)
         ok = 1'b0;
      cs_n <= ~sel;
      register_select <= rs;
      rw_wr_n <= bus80 | rd;
      data_in <= rd ? ~wd : wd;
      @(negedge clk);
      if (!bus80)
         strobe_e_rd_n <= 1'b1;
      else if (rd)
         strobe_e_rd_n <= 1'b0;
      else
         rw_wr_n <= 1'b0;
      repeat (5) @(negedge clk);
      rv = data_out;
      oe = data_oe;
      strobe_e_rd_n <= bus80;
      if (bus80)
         rw_wr_n <= 1'b1;
      repeat (2) @(negedge clk);
      cs_n <= 1'b1;
      // a released bus must not keep its last value
      data_in <= ~wd;
      repeat (3) @(negedge clk);
   endtask
endmodule // host_bus_model

// ===== test/test_lcd_segment_mpu_port_ctrl.sv
// self-checking bench of the segment driver host port
// assumes host_bus_model and the design package are compiled first
`timescale 1ns/1ps
module test_lcd_segment_mpu_port_ctrl;
   import lcd_port_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hw_reset_pin = 1'b1;
   logic display_clock_in = 1'b0;
   logic cs_n, register_select, strobe_e_rd_n, rw_wr_n, data_oe, busy, oe_seen;
   logic [7:0] data_in, data_out, r;
   logic [4:0] line;
   disp_ctrl_type st;
   int miscompares = 0;
   int total_checks = 0;

   always #4 clk = ~clk;

   lcd_segment_mpu_port_ctrl lcd_segment_mpu_port_ctrl_inst (.clk(clk), .srst(srst),
      .cs_n(cs_n), .register_select(register_select), .strobe_e_rd_n(strobe_e_rd_n),
      .rw_wr_n(rw_wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .hw_reset_pin(hw_reset_pin), .display_clock_in(display_clock_in), .settings(st),
      .busy(busy));
   host_bus_model host_bus_model_inst (.clk(clk), .data_out(data_out), .data_oe(data_oe),
      .busy(busy), .cs_n(cs_n), .register_select(register_select),
      .strobe_e_rd_n(strobe_e_rd_n), .rw_wr_n(rw_wr_n), .data_in(data_in));

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic acc(input logic rs, input logic rd, input logic sel, input logic wt,
         input logic [7:0] wd);
      logic ok;
      host_bus_model_inst.access(rs, rd, sel, wt, wd, r, oe_seen, ok);
      if (ok !== 1'b1)
      begin
         miscompares++;
         close_out();
      end
   endtask

   task automatic cmd(input logic [7:0] d);
      acc(1'b0, 1'b0, 1'b1, 1'b1, d);
   endtask

   task automatic dat(input logic [7:0] d);
      acc(1'b1, 1'b0, 1'b1, 1'b1, d);
   endtask

   task automatic rdchk(input logic rs, input logic [7:0] e);
      acc(rs, 1'b1, 1'b1, 1'b1, 8'h00);
      check("read", r, e);
   endtask

   // display clock pulses, slow against the system clock like the real one
   task automatic dclk(input int n);
      repeat (n)
      begin
         display_clock_in = 1'b1;
         repeat (4) @(negedge clk);
         display_clock_in = 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask

   task automatic t_after_reset();
      rdchk(1'b0, 8'h60);
      check("oe", oe_seen, 1'b1);
      check("page", st.page, 2'h3);
      check("line", st.start_line, 5'h00);
   endtask

   task automatic t_data_path();
      cmd(8'hb8);
      cmd(8'h05);
      dat(8'ha5);
      dat(8'h3c);
      check("column", st.column, 7'h07);
      cmd(8'h05);
      rdchk(1'b1, 8'h05);
      rdchk(1'b1, 8'ha5);
      rdchk(1'b1, 8'h3c);
      check("page", st.page, 2'h0);
   endtask

   task automatic t_rmw();
      cmd(8'h0a);
      cmd(8'he0);
      dat(8'h77);
      check("column", st.column, 7'h0b);
      acc(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
      check("column", st.column, 7'h0b);
      cmd(8'h20);
      check("column", st.column, 7'h0b);
      cmd(8'hee);
      check("column", st.column, 7'h0a);
   endtask

   task automatic t_col_end();
      cmd(8'h4f);
      dat(8'h01);
      dat(8'h02);
      dat(8'h03);
      check("column", st.column, 7'h50);
      check("page", st.page, 2'h0);
   endtask

   task automatic t_soft_reset();
      acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
      check("oe", oe_seen, 1'b0);
      acc(1'b0, 1'b0, 1'b0, 1'b1, 8'h30);
      check("column", st.column, 7'h50);
      acc(1'b0, 1'b0, 1'b0, 1'b1, 8'he2);
      check("busy", busy, 1'b1);
      rdchk(1'b0, 8'h60);
      check("page", st.page, 2'h3);
      check("line", st.start_line, 5'h00);
      cmd(8'hb8);
      cmd(8'h05);
      acc(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
      rdchk(1'b1, 8'ha5);
   endtask

   task automatic t_power_save();
      cmd(8'hae);
      check("psave", st.power_save, 1'b0);
      cmd(8'ha5);
      check("psave", st.power_save, 1'b1);
      check("hold", st.hold_lcd_drive_level, 1'b1);
      check("run", st.drive_run, 1'b0);
      line = st.drive_line;
      dclk(3);
      check("line", st.drive_line, line);
      check("adc", st.adc_normal, 1'b1);
      check("page", st.page, 2'h0);
      cmd(8'ha4);
      check("psave", st.power_save, 1'b0);
      dclk(3);
      check("moved", st.drive_line !== line, 1'b1);
      cmd(8'ha5);
      cmd(8'haf);
      check("psave", st.power_save, 1'b0);
   endtask

   task automatic t_hw_reset();
      cmd(8'hb9);
      @(negedge clk);
      hw_reset_pin = 1'b0;
      repeat (10) @(negedge clk);
      acc(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
      check("rst_flag", r[4], 1'b1);
      check("busy_bit", r[7], 1'b1);
      acc(1'b0, 1'b0, 1'b1, 1'b0, 8'hb8);
      check("page", st.page, 2'h3);
      hw_reset_pin = 1'b1;
      acc(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
      check("rst_flag", r[4], 1'b0);
      check("page", st.page, 2'h3);
   endtask

   // second reset in mid-run with the reset pin low: the port must come up 80-style
   task automatic t_bus80();
      @(negedge clk);
      srst = 1'b1;
      hw_reset_pin = 1'b0;
      host_bus_model_inst.park(1'b1);
      repeat (6) @(negedge clk);
      srst = 1'b0;
      rdchk(1'b0, 8'h60);
      check("oe", oe_seen, 1'b1);
      cmd(8'h12);
      dat(8'h96);
      check("column", st.column, 7'h13);
      cmd(8'h12);
      acc(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
      check("stale", r, 8'h12);
      rdchk(1'b1, 8'h96);
   endtask

   initial
   begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      t_after_reset();
      t_data_path();
      t_rmw();
      t_col_end();
      t_soft_reset();
      t_power_save();
      t_hw_reset();
      t_bus80();
      close_out();
   end
endmodule // test_lcd_segment_mpu_port_ctrl
